// ==== rtl/sar_seq_pkg.sv ====
// Constants, types and timing for the successive-approximation sequencer.
// Assumes one 25 MHz clock; host pins arrive asynchronously and are synchronised.
// How it works
// [R1] Each conversion makes exactly eight trial comparisons to pick one of 256 ladder levels.
// [R2] A nine-stage one-hot pointer marks the bit under test and eight latches keep outcomes.
// [R3] Trials run from the top bit down, each first setting the tested bit and routing its tap.
// [R4] An input above the trial tap keeps the tested bit at one.
// [R5] An input below the trial tap clears the tested bit before the next lower trial.
// [R6] Only after the eighth comparison are the latches copied into the result register.
// [R7] The result register keeps the old value during a conversion and changes only at transfer.
// [R8] The tap decoder picks one of 256 taps from the current trial code.
// [R9] The input selector connects exactly one of 11 channels from the channel selection.
// [R10] Six inputs are also readable as discrete logic levels, with no guarantee of valid levels.
// [R11] The host port is eight bits wide and its drivers are released when not driving.
// [R12] A conversion spends 32 clocks acquiring, then finishes at 256 clocks and goes idle.
// [R13] A completion flag is set when a new result is stored and reading does not clear it.
// [R14] A start command during a conversion aborts it and begins a fresh acquisition.
// [R15] The device clears the start bit itself once it begins the conversion cycle.
// [R16] Reset returns the sequencer to idle with the pointer clear and the result untouched.
package sar_seq_pkg;

   // Conversion timing in clocks
   localparam int         ACQ_CLKS   = 32;
   localparam int         CONV_CLKS  = 256;
   localparam int         N_TRIALS   = 8;
   localparam int         TRIAL_CLKS = (CONV_CLKS - ACQ_CLKS) / N_TRIALS;
   localparam logic [7:0] ACQ_LAST   = 8'(ACQ_CLKS - 1);
   localparam logic [7:0] TRIAL_LAST = 8'(TRIAL_CLKS - 1);

   // Sizes
   localparam int N_TAPS     = 256;
   localparam int N_CHANNELS = 11;
   localparam int N_DISCRETE = 6;

   // Pointer codes: top stage marks acquisition, lower eight the bit under test
   localparam logic [8:0] PTR_CLEAR = 9'h000;
   localparam logic [8:0] PTR_ACQ   = 9'h100;
   localparam logic [8:0] PTR_MSB   = 9'h080;

   // Register select and field positions
   localparam logic RS_RESULTS   = 1'b0;
   localparam logic RS_CONTROL   = 1'b1;
   localparam int   START_BIT    = 0;
   localparam int   STATUS_BIT   = 7;
   localparam int   CHAN_LSB     = 0;
   localparam logic [3:0] CHAN_RESET = 4'h0;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ  = 2'b01,
      ST_CONV = 2'b10
   } seq_state_e;

   // Host pins as sampled
   typedef struct packed {
      logic       cs_n;
      logic       rd;
      logic       rs;
      logic       stb;
      logic [7:0] data;
   } host_in_s;

endpackage

// ==== rtl/tap_tree_decoder.sv ====
// One-hot selector from a binary code, used for ladder taps and input channels.
// Assumes the code is stable for the cycle it is read; output is combinational.
`timescale 1ns/1ps
module tap_tree_decoder #(
   parameter int SEL_W = 8,
   parameter int N     = 256
) (
   input  wire logic [SEL_W-1:0] sel,
   output wire logic [N-1:0]     onehot
);

   // Refuse more outputs than the code can address
   if (N > (2 ** SEL_W) || N < 1) begin : g_bad
      $error("tap_tree_decoder: N does not fit SEL_W");
   end

   // One compare per output line
   for (genvar i = 0; i < N; i++) begin : g_line
      assign onehot[i] = (sel == SEL_W'(i));
   end

endmodule

// ==== rtl/sar_conversion_sequencer.sv ====
// Successive-approximation sequencer with host byte port and input selection.
// Assumes host pins, comparator and discrete inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module sar_conversion_sequencer
   import sar_seq_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire host_in_s              host_in,
   output logic       [7:0]           host_data_out,
   output logic                       host_data_oe,
   input  wire logic                  comp_above,
   input  wire logic [N_DISCRETE-1:0] discrete_in,
   output wire logic [7:0]            trial_code,
   output wire logic [N_TAPS-1:0]     tap_sel,
   output wire logic [N_CHANNELS-1:0] chan_sel,
   output logic       [7:0]           result,
   output logic                       done_flag,
   output logic                       busy
);

   host_in_s                h1, h2, h3;
   logic                    comp1, comp_s;
   logic [N_DISCRETE-1:0]   disc1, disc_s;
   seq_state_e              state;
   logic [7:0]              cnt;
   logic [8:0]              ptr;
   logic [7:0]              latches;
   logic                    begin_conversion_bit;
   logic                    start_req;
   logic [3:0]              channel;
   logic                    byte_lsb;
   logic [7:0]              next_latches;
   logic [7:0]              next_byte;
   logic [3:0]              chan_index;
   logic                    stb_evt, wr_ctrl, wr_ms, wr_ls, decide, xfer;

   // Two-flop synchronisers; h3 only for strobe edge detect
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         h1     <= '0;
         h2     <= '0;
         h3     <= '0;
         comp1  <= 1'b0;
         comp_s <= 1'b0;
         disc1  <= '0;
         disc_s <= '0;
      end else begin
         h1     <= host_in;
         h2     <= h1;
         h3     <= h2;
         comp1  <= comp_above;
         comp_s <= comp1;
         disc1  <= discrete_in;
         disc_s <= disc1;
      end
   end

   // Host byte decode
   assign stb_evt = h2.stb & ~h3.stb & ~h2.cs_n;
   assign wr_ctrl = stb_evt & ~h2.rd & (h2.rs == RS_CONTROL);
   assign wr_ms   = wr_ctrl & ~byte_lsb;
   assign wr_ls   = wr_ctrl & byte_lsb;

   // Byte counter: MS first, back to MS while deselected
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         byte_lsb <= 1'b0;
      end else if (h2.cs_n) begin
         byte_lsb <= 1'b0;
      end else if (stb_evt) begin
         byte_lsb <= ~byte_lsb;
      end
   end

   // Control word: start request in MS byte, channel in LS byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_req            <= 1'b0;
         channel              <= CHAN_RESET;
         begin_conversion_bit <= 1'b0;
      end else begin
         begin_conversion_bit <= 1'b0;                      // see [R15]
         if (wr_ms) begin
            start_req <= h2.data[START_BIT];
         end
         if (wr_ls) begin
            channel              <= h2.data[CHAN_LSB +: 4];
            begin_conversion_bit <= start_req;
            start_req            <= 1'b0;
         end
      end
   end

   // Sequencer decode
   assign decide       = (state == ST_CONV) && (cnt == TRIAL_LAST);
   assign xfer         = decide && ptr[0];                  // see [R6]
   assign next_latches = comp_s ? (latches | ptr[7:0]) : latches;   // see [R4] see [R5]
   assign trial_code   = (state == ST_CONV) ? (latches | ptr[7:0]) : latches;  // see [R3]

   // Sequencer: acquire, eight trials, transfer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state   <= ST_IDLE;                                // see [R16]
         cnt     <= 8'h00;
         ptr     <= PTR_CLEAR;
         latches <= 8'h00;
      end else if (begin_conversion_bit) begin
         state   <= ST_ACQ;                                 // see [R14]
         cnt     <= 8'h00;
         ptr     <= PTR_ACQ;
         latches <= 8'h00;
      end else begin
         case (state)
            ST_ACQ: begin
               cnt <= cnt + 8'h01;
               if (cnt == ACQ_LAST) begin                   // see [R12]
                  state <= ST_CONV;
                  cnt   <= 8'h00;
                  ptr   <= PTR_MSB;                         // see [R3]
               end
            end
            ST_CONV: begin
               cnt <= cnt + 8'h01;
               if (decide) begin                            // see [R1]
                  cnt     <= 8'h00;
                  latches <= next_latches;
                  ptr     <= ptr >> 1;                      // see [R2]
                  if (ptr[0]) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               cnt <= 8'h00;
               ptr <= PTR_CLEAR;
            end
            default: begin
               state <= ST_IDLE;
               cnt   <= 8'h00;
               ptr   <= PTR_CLEAR;
            end
         endcase
      end
   end

   // Result register, deliberately outside reset
   always_ff @(posedge sys_clk) begin
      if (xfer) begin
         result <= next_latches;                            // see [R7]
      end
   end

   // Completion flag; a new result wins over a clearing write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done_flag <= 1'b0;
      end else if (xfer) begin
         done_flag <= 1'b1;                                 // see [R13]
      end else if (wr_ls) begin
         done_flag <= 1'b0;
      end
   end

   // Read byte select: results word or discrete word
   always_comb begin
      next_byte = 8'h00;
      if (h2.rs == RS_RESULTS) begin
         next_byte = byte_lsb ? result : 8'(done_flag) << STATUS_BIT;
      end else begin
         next_byte = byte_lsb ? {channel[1:0], 6'h00}
                              : {disc_s, channel[3:2]};     // see [R10]
      end
   end

   // Output drivers enabled only during a selected read
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         host_data_out <= 8'h00;
         host_data_oe  <= 1'b0;
         busy          <= 1'b0;
      end else begin
         host_data_out <= next_byte;
         host_data_oe  <= ~h2.cs_n & h2.rd;                 // see [R11]
         busy          <= (state != ST_IDLE) | begin_conversion_bit;
      end
   end

   // Channel code to index: 0-5 direct, A-D to 7-10, others to 6
   assign chan_index = (channel <= 4'h5) ? channel :
                       (channel >= 4'hA && channel <= 4'hD) ? (channel - 4'h3) : 4'h6;

   // Ladder tap and channel selectors
   tap_tree_decoder #(.SEL_W(8), .N(N_TAPS)) u_tap (
      .sel    (trial_code),
      .onehot (tap_sel)                                     // see [R8]
   );
   tap_tree_decoder #(.SEL_W(4), .N(N_CHANNELS)) u_chan (
      .sel    (chan_index),
      .onehot (chan_sel)                                    // see [R9]
   );

   // Cycles since acquisition began, for checks only
   logic [8:0] conv_len;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conv_len <= 9'h000;
      end else if (begin_conversion_bit) begin
         conv_len <= 9'h000;
      end else if (state != ST_IDLE) begin
         conv_len <= conv_len + 9'h001;
      end
   end

   // Checks
   a_acq_to_conv: assert property (@(posedge sys_clk) disable iff (rst)   // see [R12]
      (state == ST_ACQ && cnt == ACQ_LAST && !begin_conversion_bit)
      |=> (state == ST_CONV && ptr == PTR_MSB))
      else $error("acquisition did not hand over to trials");
   a_conv_length: assert property (@(posedge sys_clk) disable iff (rst)   // see [R1]
      xfer |-> conv_len == 9'd255)
      else $error("conversion length is not 256 clocks");
   a_msb_first: assert property (@(posedge sys_clk) disable iff (rst)     // see [R3]
      (state == ST_CONV && ptr == PTR_MSB) |-> trial_code[7])
      else $error("top bit not set in first trial");
   a_keep_high: assert property (@(posedge sys_clk) disable iff (rst)     // see [R4]
      (decide && comp_s && !begin_conversion_bit)
      |=> (latches & $past(ptr[7:0])) != 8'h00)
      else $error("tested bit dropped on high compare");
   a_clear_low: assert property (@(posedge sys_clk) disable iff (rst)     // see [R5]
      (decide && !comp_s && !begin_conversion_bit)
      |=> (latches & $past(ptr[7:0])) == 8'h00)
      else $error("tested bit kept on low compare");
   a_result_hold: assert property (@(posedge sys_clk) disable iff (rst)   // see [R7]
      (!xfer ##1 1'b1) |-> $stable(result))
      else $error("result changed outside transfer");
   a_ptr_onehot: assert property (@(posedge sys_clk) disable iff (rst)    // see [R2]
      $onehot0(ptr) && ((state == ST_IDLE) == (ptr == PTR_CLEAR)))
      else $error("pointer not one-hot");
   a_tap_onehot: assert property (@(posedge sys_clk) disable iff (rst)    // see [R8]
      $onehot(tap_sel) && tap_sel[trial_code])
      else $error("tap selection wrong");
   a_chan_onehot: assert property (@(posedge sys_clk) disable iff (rst)   // see [R9]
      $onehot(chan_sel))
      else $error("channel selection not one-hot");
   a_start_clear: assert property (@(posedge sys_clk) disable iff (rst)   // see [R15]
      begin_conversion_bit |=> (!begin_conversion_bit && state == ST_ACQ && cnt == 8'h00))
      else $error("start bit not cleared or acquisition not begun");
   a_status_set: assert property (@(posedge sys_clk) disable iff (rst)    // see [R13]
      xfer |=> done_flag [*2])
      else $error("completion flag not held");
   a_oe_release: assert property (@(posedge sys_clk) disable iff (rst)    // see [R11]
      h2.cs_n |=> !host_data_oe)
      else $error("drivers enabled while deselected");

   c_full_conv: cover property (@(posedge sys_clk) disable iff (rst) xfer);
   c_abort: cover property (@(posedge sys_clk) disable iff (rst)
      (state == ST_CONV) && begin_conversion_bit);
   c_status_read: cover property (@(posedge sys_clk) disable iff (rst)
      done_flag && host_data_oe && byte_lsb);

endmodule

// ==== tb/host_bus_model.sv ====
// Host processor model driving the byte port pins of the sequencer.
// Assumes pins may change just after rising edges; the sequencer synchronises them.
`timescale 1ns/1ps
module host_bus_model
   import sar_seq_pkg::*;
(
   input  wire logic       sys_clk,
   output host_in_s        host_in,
   input  wire logic [7:0] host_data_out,
   input  wire logic       host_data_oe
);
   logic       cs_n;
   logic       rd;
   logic       rs;
   logic       stb;
   logic       drv_en;
   logic       oe_seen;
   logic [7:0] drv;
   // Wire level; a released line shows the inverse of its last value
   wire logic [7:0] bus = host_data_oe ? host_data_out : (drv_en ? drv : ~drv);
   assign host_in = {cs_n, rd, rs, stb, bus};

   // Idle bus at time zero
   initial begin
      {cs_n, rd, rs, stb, drv_en, oe_seen, drv} = {5'h10, 1'b0, 8'h00};
   end

   // One byte: select, settle, sample, strobe, hold
   task automatic xfer(input logic r, input logic s, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge sys_clk);
      {cs_n, rd, rs, drv, drv_en} <= {1'b0, r, s, d, !r};
      repeat (6) @(posedge sys_clk);
      q = host_data_out;
      oe_seen = host_data_oe;
      stb <= 1'b1;
      repeat (4) @(posedge sys_clk);
      stb <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   // Deselect long enough for the byte counter to return to the MS byte
   task automatic end_word();
      cs_n   <= 1'b1;
      drv_en <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   // Two-byte write, MS byte first; a start bit here also aborts a running one
   task automatic wr_word(input logic s, input logic [7:0] ms, input logic [7:0] ls);
      logic [7:0] q;
      xfer(1'b0, s, ms, q);
      xfer(1'b0, s, ls, q);
      end_word();
   endtask

   // Two-byte read, MS byte first
   task automatic rd_word(input logic s, output logic [7:0] ms, output logic [7:0] ls);
      xfer(1'b1, s, 8'h00, ms);
      xfer(1'b1, s, 8'h00, ls);
      end_word();
   endtask
endmodule

// ==== tb/tb_sar_conversion_sequencer.sv ====
// Bench for the conversion sequencer with host and comparator models.
// Assumes the package and the host model are compiled before this file.
`timescale 1ns/1ps
module tb_sar_conversion_sequencer
   import sar_seq_pkg::*;
;
   logic                  sys_clk;
   logic                  rst;
   host_in_s              host_in;
   logic [7:0]            host_data_out;
   logic                  host_data_oe;
   logic                  comp_above;
   logic [N_DISCRETE-1:0] discrete_in;
   logic [7:0]            trial_code;
   logic [N_TAPS-1:0]     tap_sel;
   logic [N_CHANNELS-1:0] chan_sel;
   logic [7:0]            result;
   logic                  done_flag;
   logic                  busy;
   logic [7:0]            vin;
   int                    mismatches;
   int                    num_checks;

   sar_conversion_sequencer i_dut (.sys_clk(sys_clk), .rst(rst), .host_in(host_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .comp_above(comp_above),
      .discrete_in(discrete_in), .trial_code(trial_code), .tap_sel(tap_sel),
      .chan_sel(chan_sel), .result(result), .done_flag(done_flag), .busy(busy));
   host_bus_model i_host (.sys_clk(sys_clk), .host_in(host_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe));

   // Comparator: input code above or at the trial tap
   assign comp_above = (vin >= trial_code);

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Reset values at the pins
   task automatic t_reset(input logic [7:0] res);
      check("busy", busy, 1'b0);
      check("done", done_flag, 1'b0);
      check("oe", host_data_oe, 1'b0);
      check("chan", chan_sel, 11'h001);
      check("tap", tap_sel, 256'h1);
      check("kept", result, res);
   endtask

   // Full conversion, watched through acquisition and the first two trials, then read back twice
   task automatic t_conv(input logic [3:0] ch, input int idx, input logic [7:0] v);
      int n;
      logic [7:0] old;
      logic [7:0] ms;
      logic [7:0] ls;
      n = 0;
      old = result;
      vin <= v;
      fork
         i_host.wr_word(1'b1, 8'h01, {4'h0, ch});
         begin
            while (busy !== 1'b1 && n < 100) begin
               @(posedge sys_clk);
               n++;
            end
            // Busy first seen here shows acquisition clock 0; last acquisition clock 31
            repeat (31) @(posedge sys_clk);
            check("acq", trial_code, 8'h00);
            @(posedge sys_clk);
            check("msb", trial_code, 8'h80);
            repeat (29) @(posedge sys_clk);
            check("bit6", trial_code, (v & 8'h80) | 8'h40);
            check("tap", tap_sel, 256'h1 << trial_code);
            check("chan", chan_sel, 11'h1 << idx);
            check("held", result, old);
            // Count clocks until the completion flag shows the transfer
            n = 61;
            while (done_flag !== 1'b1 && n < 400) begin
               @(posedge sys_clk);
               n++;
            end
         end
      join
      check("len", n, CONV_CLKS);
      check("result", result, v);
      repeat (2) begin
         i_host.rd_word(1'b0, ms, ls);
         check("status", ms, 8'h80);
         check("data", ls, v);
         check("oe_rd", i_host.oe_seen, 1'b1);
      end
      check("oe_off", host_data_oe, 1'b0);
      check("idle", busy, 1'b0);
   endtask

   // Restart in mid-conversion, then an ignored no-op write
   task automatic t_abort();
      int n;
      n = 0;
      vin <= 8'h5A;
      i_host.wr_word(1'b1, 8'h01, 8'h03);
      repeat (60) @(posedge sys_clk);
      check("held", result, 8'h80);
      check("cleared", done_flag, 1'b0);
      vin <= 8'h33;
      i_host.wr_word(1'b1, 8'h01, 8'h03);
      while (busy === 1'b1 && n < 600) begin
         @(posedge sys_clk);
         n++;
      end
      check("restart", n > 230, 1'b1);
      check("fresh", result, 8'h33);
      i_host.wr_word(1'b0, 8'h01, 8'h05);
      repeat (10) @(posedge sys_clk);
      check("noop", {busy, chan_sel}, {1'b0, 11'h008});
   endtask

   // Discrete levels and channel code read back
   task automatic t_discrete();
      logic [7:0] ms;
      logic [7:0] ls;
      discrete_in <= 6'h2D;
      i_host.wr_word(1'b1, 8'h00, 8'h0B);
      check("chan_b", chan_sel, 11'h100);
      i_host.rd_word(1'b1, ms, ls);
      check("disc_ms", ms, 8'hB6);
      check("disc_ls", ls, 8'hC0);
   endtask

   // Reset during a conversion keeps the old result
   task automatic t_midreset();
      vin <= 8'h44;
      i_host.wr_word(1'b1, 8'h01, 8'h01);
      repeat (40) @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_reset(8'h33);
      rst <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      conclude();
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      vin = 8'h00;
      discrete_in = 6'h00;
      mismatches = 0;
      num_checks = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t_reset(result);
      t_conv(4'h2, 2, 8'hA5);
      t_conv(4'h0, 0, 8'h00);
      t_conv(4'hA, 7, 8'hFF);
      t_conv(4'hD, 10, 8'h7F);
      t_conv(4'h7, 6, 8'h80);
      t_abort();
      t_discrete();
      t_midreset();
      conclude();
   end
endmodule
